/* src/cfg_ctrl_defs.svh */
// timing counts and fixed values for the configuration handshake
`ifndef CFG_CTRL_DEFS_SVH
`define CFG_CTRL_DEFS_SVH
`define CLK_PERIOD_NS 20
`define HOLD_TIME_US 100
`define HOLD_CYCLES ((`HOLD_TIME_US * 1000) / `CLK_PERIOD_NS)
`define CNT_W 24
`define INIT_TIME_NS 200
`define INIT_CYCLES ((`INIT_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

/* src/cfg_ctrl_pkg.sv */
// types shared by both ends of the configuration handshake
`default_nettype none
package cfg_ctrl_pkg;
    typedef enum logic [6:0] {
        ST_HOLD   = 7'h01,
        ST_IDLE   = 7'h02,
        ST_LOAD   = 7'h04,
        ST_ERROR  = 7'h08,
        ST_INIT   = 7'h10,
        ST_USER   = 7'h20,
        ST_WAIT_CFG = 7'h40
    } cfg_state_t;
    typedef enum logic [3:0] {
        HS_IDLE = 4'h1,
        HS_REQ  = 4'h2,
        HS_SEND = 4'h4,
        HS_DONE = 4'h8
    } host_state_t;
endpackage : cfg_ctrl_pkg
`default_nettype wire

/* src/cfg_link_if.sv */
// wired link between the configurable device and its configuration host
`timescale 1ns/100ps
`default_nettype none
interface cfg_link_if;
    logic cfg_request_n;
    logic chain_sel_in_n;
    logic chain_sel_out_n;
    logic status_dev_oe;
    logic status_host_oe;
    logic status_line;
    logic done_dev_oe;
    logic done_host_oe;
    logic load_complete_line;
    logic data_valid;
    logic data_bit;
    logic flash_command_out;
    logic flash_select_out;
    // open-drain resolution with pull-ups
    assign status_line = ~(status_dev_oe | status_host_oe);
    assign load_complete_line = ~(done_dev_oe | done_host_oe);
    modport device (
        input cfg_request_n, chain_sel_in_n, status_line, load_complete_line, data_valid, data_bit,
        output chain_sel_out_n, status_dev_oe, done_dev_oe, flash_command_out, flash_select_out
    );
    modport host (
        output cfg_request_n, chain_sel_in_n, status_host_oe, done_host_oe, data_valid, data_bit,
        input chain_sel_out_n, status_line, load_complete_line, flash_command_out, flash_select_out
    );
endinterface : cfg_link_if
`default_nettype wire

/* src/cfg_host_end.sv */
// configuration host: requests a load, streams words, watches status lines
`timescale 1ns/100ps
`default_nettype none
`include "cfg_ctrl_defs.svh"
module cfg_host_end
    import cfg_ctrl_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    cfg_link_if.host link,
    input wire logic start,
    input wire logic [15:0] word_count,
    input wire logic reconfig,
    input wire logic force_error,
    output logic busy,
    output logic load_ok,
    output logic load_failed
);
    host_state_t state, next_state;
    logic [15:0] sent, next_sent;
    logic ok, next_ok, failed, next_failed, req_n, next_req_n;

    // host sequencing: pulse request low, wait for status high, send bits
    always_comb begin
        next_state = state;
        next_sent = sent;
        next_ok = ok;
        next_failed = failed;
        next_req_n = req_n;
        unique case (state)
            HS_IDLE: begin
                if (start || reconfig) begin
                    next_req_n = 1'b0;
                    next_state = HS_REQ;
                    next_ok = 1'b0;
                    next_failed = 1'b0;
                end
            end
            HS_REQ: begin
                next_req_n = 1'b1;
                next_sent = 16'h0000;
                if (req_n && link.status_line) begin
                    next_state = HS_SEND;
                end
            end
            HS_SEND: begin
                if (!link.status_line) begin
                    next_failed = 1'b1;
                    next_state = HS_IDLE;
                end else if (sent == word_count) begin
                    next_state = HS_DONE;
                end else begin
                    next_sent = sent + 16'h0001;
                end
            end
            HS_DONE: begin
                if (!link.status_line) begin
                    next_failed = 1'b1;
                    next_state = HS_IDLE;
                end else if (link.load_complete_line) begin
                    next_ok = 1'b1;
                    next_state = HS_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state <= HS_IDLE;
            sent <= 16'h0000;
            ok <= 1'b0;
            failed <= 1'b0;
            req_n <= 1'b1;
        end else if (clk_en) begin
            state <= next_state;
            sent <= next_sent;
            ok <= next_ok;
            failed <= next_failed;
            req_n <= next_req_n;
        end
    end

    assign link.cfg_request_n = req_n;
    assign link.chain_sel_in_n = 1'b0;
    assign link.status_host_oe = force_error && (state == HS_SEND);
    assign link.done_host_oe = 1'b0;
    assign link.data_valid = (state == HS_SEND) && (sent != word_count);
    assign link.data_bit = sent[0];
    assign busy = (state != HS_IDLE);
    assign load_ok = ok;
    assign load_failed = failed;
endmodule : cfg_host_end
`default_nettype wire

/* src/cfg_device_end.sv */
// configurable device end: power-on hold, load, error, init, user mode
// How it works
// - load only while request input high; scan ignores
// - hold status low until power-on hold expires
// - load error pulls status line low
// - status sensed low during load means error
// - user mode ignores status line, no reload
// - host pulls request low to force reload
// - load-complete held low before and during load
// - release load-complete when all words good
// - enter user mode after load-complete sensed high
// - user mode ignores load-complete driven low
// - load only while chain-select input low
// - host holds chain-select low for scan programming
// - chain-select output low once configured
// - chain: first tied low, output feeds next
// - self-driven mode drives flash command output
// - self-driven mode drives flash select low
// - late hold keeps status low, then retries
// - request low in user mode resets device
`timescale 1ns/100ps
`default_nettype none
`include "cfg_ctrl_defs.svh"
module cfg_device_end
    import cfg_ctrl_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    cfg_link_if.device link,
    input wire logic power_good,
    input wire logic scan_mode,
    input wire logic self_driven_serial_load,
    input wire logic [15:0] word_count,
    input wire logic crc_error,
    output logic user_mode,
    output logic io_tristate,
    output logic config_error,
    output logic [15:0] words_received
);
    // sequencer state, counters and open-drain drive enables
    cfg_state_t state, next_state;
    logic [`CNT_W-1:0] hold_cnt, next_hold_cnt;
    logic [3:0] init_cnt, next_init_cnt;
    logic [15:0] rx, next_rx;
    logic err, next_err, cmd_bit, next_cmd_bit;
    logic drive_status, drive_done;

    // request is honoured unless scan programming overrides it
    function automatic logic req_low(input logic req_n, input logic scan);
        req_low = !req_n && !scan;
    endfunction : req_low

    // the flash is read only while loading in self-driven mode
    function automatic logic reading_flash(input logic self_driven, input cfg_state_t st);
        reading_flash = self_driven && (st == ST_LOAD);
    endfunction : reading_flash

    // main configuration state sequencing
    always_comb begin
        next_state = state;
        next_hold_cnt = hold_cnt;
        next_init_cnt = init_cnt;
        next_rx = rx;
        next_err = err;
        next_cmd_bit = cmd_bit;
        unique case (state)
            ST_HOLD: begin
                // count only once supply is good; a late trip restarts the wait
                if (!power_good) begin
                    next_hold_cnt = '0;
                end else if (hold_cnt == `CNT_W'(`HOLD_CYCLES - 1)) begin
                    next_state = ST_IDLE;
                end else begin
                    next_hold_cnt = hold_cnt + `CNT_W'(1);
                end
            end

            ST_IDLE: begin
                // start once request is high, chain enabled and status released
                next_rx = 16'h0000;
                next_err = 1'b0;
                if (req_low(link.cfg_request_n, scan_mode)) begin
                    next_state = ST_WAIT_CFG;
                end else if (!link.chain_sel_in_n && link.status_line) begin
                    next_state = ST_LOAD;
                end
            end

            ST_LOAD: begin
                // request, faults and deselect take priority over counting
                next_cmd_bit = ~cmd_bit;
                if (req_low(link.cfg_request_n, scan_mode)) begin
                    next_state = ST_WAIT_CFG;
                end else if (crc_error) begin
                    next_err = 1'b1;
                    next_state = ST_ERROR;
                end else if (!link.status_line) begin
                    next_err = 1'b1;
                    next_state = ST_ERROR;
                end else if (link.chain_sel_in_n) begin
                    next_state = ST_LOAD;
                end else if (rx == word_count) begin
                    next_init_cnt = 4'h0;
                    next_state = ST_INIT;
                end else if (link.data_valid) begin
                    next_rx = rx + 16'h0001;
                end
            end

            ST_ERROR: begin
                // wait for a fresh request pulse to retry
                if (req_low(link.cfg_request_n, scan_mode)) begin
                    next_state = ST_WAIT_CFG;
                end
            end

            ST_INIT: begin
                // count the init cycles while the load-complete line reads high
                if (req_low(link.cfg_request_n, scan_mode)) begin
                    next_state = ST_WAIT_CFG;
                end else if (!link.status_line) begin
                    next_err = 1'b1;
                    next_state = ST_ERROR;
                end else if (link.load_complete_line) begin
                    if (init_cnt == 4'(`INIT_CYCLES - 1)) begin
                        next_state = ST_USER;
                    end else begin
                        next_init_cnt = init_cnt + 4'h1;
                    end
                end
            end

            ST_USER: begin
                // status and load-complete lines are not looked at here
                if (req_low(link.cfg_request_n, scan_mode)) begin
                    next_state = ST_WAIT_CFG;
                end
            end

            ST_WAIT_CFG: begin
                // both lines stay low until the request returns high
                next_rx = 16'h0000;
                next_err = 1'b0;
                if (link.cfg_request_n) begin
                    next_state = ST_IDLE;
                end
            end
        endcase
    end

    // sequencer registers; clk_en low holds everything
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state <= ST_HOLD;
            hold_cnt <= '0;
            init_cnt <= 4'h0;
            rx <= 16'h0000;
            err <= 1'b0;
            cmd_bit <= 1'b0;
        end else if (clk_en) begin
            state <= next_state;
            hold_cnt <= next_hold_cnt;
            init_cnt <= next_init_cnt;
            rx <= next_rx;
            err <= next_err;
            cmd_bit <= next_cmd_bit;
        end
    end

    // open-drain drive enables per state; the wired levels come back through the link
    always_comb begin
        drive_status = 1'b0;
        drive_done = 1'b0;
        unique case (state)
            ST_HOLD, ST_ERROR, ST_WAIT_CFG: begin
                drive_status = 1'b1;
                drive_done = 1'b1;
            end
            ST_IDLE, ST_LOAD: begin
                drive_done = 1'b1;
            end
            ST_INIT, ST_USER: begin
                drive_status = 1'b0;
                drive_done = 1'b0;
            end
        endcase
    end

    // open-drain enables onto the link
    assign link.status_dev_oe = drive_status;
    assign link.done_dev_oe = drive_done;

    // chain output tells the next device it may load
    assign link.chain_sel_out_n = !(state == ST_USER);

    // flash outputs are active only while reading in self-driven mode
    assign link.flash_select_out = !reading_flash(self_driven_serial_load, state);
    assign link.flash_command_out = reading_flash(self_driven_serial_load, state) && cmd_bit;

    // status outputs for the surrounding logic
    assign user_mode = (state == ST_USER);
    assign io_tristate = (state != ST_USER);
    assign config_error = err;
    assign words_received = rx;
endmodule : cfg_device_end
`default_nettype wire

/* bench/cfg_link_chk.sv */
// assertions on the link between device and host
`timescale 1ns/100ps
`default_nettype none
module cfg_link_chk (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic cfg_request_n,
    input wire logic chain_sel_in_n,
    input wire logic chain_sel_out_n,
    input wire logic status_dev_oe,
    input wire logic status_host_oe,
    input wire logic done_dev_oe,
    input wire logic load_complete_line,
    input wire logic data_valid
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    // hold state pulls both lines and keeps chain out high
    property p_hold;
        $fell(rst) |-> status_dev_oe && done_dev_oe && chain_sel_out_n;
    endproperty
    a_hold: assert property (p_hold) else $error("hold lines wrong");
    // load-complete held low while words arrive
    property p_load_low;
        data_valid && chain_sel_out_n |-> done_dev_oe;
    endproperty
    a_load_low: assert property (p_load_low) else $error("done released in load");
    // configured device drives neither line
    property p_user_quiet;
        !chain_sel_out_n |-> !status_dev_oe && !done_dev_oe;
    endproperty
    a_user_quiet: assert property (p_user_quiet) else $error("line driven in user");
    // configured stays configured while request high
    property p_user_stays;
        !chain_sel_out_n && cfg_request_n |=> !chain_sel_out_n;
    endproperty
    a_user_stays: assert property (p_user_stays) else $error("user mode lost");
    // user mode only after init with line high
    property p_init_first;
        $fell(chain_sel_out_n) |-> $past(load_complete_line, 8);
    endproperty
    a_init_first: assert property (p_init_first) else $error("user without init");
    // configured only with chain select low
    property p_chain_in;
        $fell(chain_sel_out_n) |-> !chain_sel_in_n;
    endproperty
    a_chain_in: assert property (p_chain_in) else $error("loaded while deselected");
    // outside status low in load leads to error
    property p_ext_error;
        status_host_oe && done_dev_oe && cfg_request_n |-> ##[1:3] status_dev_oe;
    endproperty
    a_ext_error: assert property (p_ext_error) else $error("no error state");
    // leaving user mode pulls both lines low
    property p_leave_user;
        $rose(chain_sel_out_n) |-> done_dev_oe && status_dev_oe;
    endproperty
    a_leave_user: assert property (p_leave_user) else $error("bad user exit");
endmodule : cfg_link_chk
`default_nettype wire

/* bench/tb_top.sv */
// self-checking bench for both link ends
`timescale 1ns/100ps
`default_nettype none
`include "cfg_ctrl_defs.svh"
module tb_top;
    logic ref_clk = 1'b0, rst = 1'b1, clk_en = 1'b1, start = 1'b0, reconfig = 1'b0;
    logic force_error = 1'b0, power_good = 1'b0, scan_mode = 1'b0, sds = 1'b1, crc_error = 1'b0;
    logic [15:0] word_count = 16'h0004;
    logic [15:0] words_received;
    logic busy, load_ok, load_failed, user_mode, io_tristate, config_error;
    int fails = 0;
    int comparisons = 0;
    cfg_link_if link ();
    cfg_device_end i_cfg_device_end (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .link(link),
        .power_good(power_good), .scan_mode(scan_mode), .self_driven_serial_load(sds),
        .word_count(word_count), .crc_error(crc_error), .user_mode(user_mode),
        .io_tristate(io_tristate), .config_error(config_error), .words_received(words_received));
    cfg_host_end i_cfg_host_end (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .link(link),
        .start(start), .word_count(word_count), .reconfig(reconfig), .force_error(force_error),
        .busy(busy), .load_ok(load_ok), .load_failed(load_failed));
    cfg_link_chk i_cfg_link_chk (.ref_clk(ref_clk), .rst(rst), .cfg_request_n(link.cfg_request_n),
        .chain_sel_in_n(link.chain_sel_in_n), .chain_sel_out_n(link.chain_sel_out_n),
        .status_dev_oe(link.status_dev_oe), .status_host_oe(link.status_host_oe),
        .done_dev_oe(link.done_dev_oe), .load_complete_line(link.load_complete_line),
        .data_valid(link.data_valid));
    // 50 MHz clock
    always #10 ref_clk = ~ref_clk;
    task automatic end_sim;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    // bounded wait on user mode, error or busy
    task automatic wt(input int sel, input logic v);
        int n;
        n = 0;
        while ((sel == 0 ? user_mode : sel == 1 ? config_error : busy) !== v && n < 300) begin
            @(negedge ref_clk);
            n++;
        end
        if (n == 300) begin
            fails++;
            end_sim();
        end
    endtask : wt
    task automatic pulse(input logic r);
        @(negedge ref_clk);
        reconfig = r;
        start = !r;
        @(negedge ref_clk);
        reconfig = 1'b0;
        start = 1'b0;
    endtask : pulse
    // late supply, then full hold count
    task automatic t_hold;
        int n;
        n = 0;
        chk("status", 0, link.status_line);
        chk("done_line", 0, link.load_complete_line);
        chk("chain_out", 1, link.chain_sel_out_n);
        repeat (50) @(negedge ref_clk);
        power_good = 1'b1;
        while (link.status_line !== 1'b1 && n < 6000) begin
            @(negedge ref_clk);
            n++;
        end
        if (n == 6000) begin
            fails++;
            end_sim();
        end
        chk("hold", 1, n >= `HOLD_CYCLES && n <= `HOLD_CYCLES + 2);
    endtask : t_hold
    task automatic t_load(input logic [15:0] w);
        int n;
        n = 0;
        wt(2, 1'b0);
        word_count = w;
        pulse(1'b0);
        // the flash must be selected while words are counted
        while (link.flash_select_out !== 1'b0 && n < 20) begin
            @(negedge ref_clk);
            n++;
        end
        if (n == 20) begin
            fails++;
            end_sim();
        end
        chk("flash_sel", 0, link.flash_select_out);
        wt(0, 1'b1);
        chk("words", w, words_received);
        chk("chain_out", 0, link.chain_sel_out_n);
        chk("done_line", 1, link.load_complete_line);
        chk("tristate", 0, io_tristate);
        chk("load_ok", 1, load_ok);
        chk("flash_sel_user", 1, link.flash_select_out);
        chk("flash_cmd_user", 0, link.flash_command_out);
    endtask : t_load
    task automatic t_reload;
        pulse(1'b1);
        wt(0, 1'b0);
        chk("tristate", 1, io_tristate);
        chk("chain_out", 1, link.chain_sel_out_n);
        t_load(16'h0001);
    endtask : t_reload
    task automatic t_scan;
        scan_mode = 1'b1;
        pulse(1'b1);
        repeat (20) @(negedge ref_clk);
        chk("user", 1, user_mode);
        scan_mode = 1'b0;
    endtask : t_scan
    // own fault or outside fault from the first load cycle, then recovery
    task automatic t_fault(input logic crc);
        wt(2, 1'b0);
        word_count = 16'h0008;
        crc_error = crc;
        force_error = !crc;
        pulse(1'b0);
        wt(1, 1'b1);
        chk("status", 0, link.status_line);
        chk("user", 0, user_mode);
        wt(2, 1'b0);
        chk("load_failed", 1, load_failed);
        chk("load_ok", 0, load_ok);
        crc_error = 1'b0;
        force_error = 1'b0;
        t_load(16'h0005);
    endtask : t_fault
    // main sequence
    initial begin
        repeat (2) @(negedge ref_clk);
        rst = 1'b0;
        t_hold();
        t_load(16'h0004);
        t_reload();
        t_scan();
        t_fault(1'b1);
        t_fault(1'b0);
        end_sim();
    end
endmodule : tb_top
`default_nettype wire
